// File: logic/plc_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE_01] After reset, synth output is twice the pre-divided reference.
// [RULE_02] Low-power divider applies in every clock source configuration.
// [RULE_03] Software: post-divider+1, multiplier, poll sync, final post-divider.
// [RULE_04] Multiplier spans 4x to 18x within allowed system range.
// [RULE_05] Post-divider is outside loop; changes do not touch lock.
// [RULE_06] Detector raises when feedback lags, lowers when it leads.
// [RULE_07] Pump 1x below code 2, 2x codes 2-5, 4x from 6.
// [RULE_08] Oscillator runs at four times target; feedback divided back.
// [RULE_09] Compare counters at N then N+K; match relaxes and sets sync.
// [RULE_10] Locked passes continue; mismatch clears sync and tightens.
// [RULE_11] External mode: no lock, loss resets and failure monitor inert.
// [RULE_12] First lock sets both flags; multiplier change or loss clears.
// [RULE_13] Relock keeps system clock sourced from the synthesizer.
// [RULE_14] Relock sets sync; sticky only if loss came from multiplier.
// [RULE_15] Stop with synth off: sticky flag restored on relock.
// [RULE_16] Sync-loss reset enable: loss asserts reset, cause recorded.
// [RULE_17] Synth mode: reset held until reference present and locked.
// [RULE_18] Failure detect enable: slow reference or feedback sets flag.
// [RULE_19] Failure reset enable: failure asserts reset, cause recorded.
// [RULE_20] Reference failure: drop lock, self-clocked until reset.
// [RULE_21] Synth failure: reference clocks system until next reset.
// [RULE_22] Both fail: reference handling first; static if self fails.
// [RULE_23] Pre-divider divides by code plus one, one to eight.
// [RULE_24] Low-power divider divides by two to the code.
// [RULE_25] Lock counts N and K are fixed constants.
module plc_ctrl
    import plc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Clock edge events, sampled as synchronous strobes
    input wire logic ref_tick_in,
    input wire logic fb_tick_in,
    input wire logic ref_lead_in,
    input wire logic fb_lead_in,
    input wire logic self_ok_in,
    input wire logic stop_synth_off_in,
    // Analog and clock-tree controls
    output plc_analog_t analog_out,
    output logic charge_raise_out,
    output logic charge_lower_out,
    output plc_src_t clk_src_out,
    output logic in_sync_out,
    output logic sys_reset_req_out
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic [2:0] post_div_q, post_div_d, fb_mul_q, fb_mul_d;
    logic [2:0] pre_div_q, pre_div_d;
    logic [3:0] lp_div_q, lp_div_d;
    logic sync_rst_en_q, sync_rst_en_d, cf_det_en_q, cf_det_en_d;
    logic cf_rst_en_q, cf_rst_en_d, synth_en_q, synth_en_d;
    logic ext_mode_q, ext_mode_d;
    logic in_sync_q, in_sync_d, sticky_q, sticky_d;
    logic sticky_save_q, sticky_save_d, mul_loss_q, mul_loss_d;
    logic sticky_cf_q, sticky_cf_d;
    plc_cause_t cause_q, cause_d;
    plc_ld_t ld_q, ld_d;
    logic [7:0] ref_cnt_q, ref_cnt_d, fb_cnt_q, fb_cnt_d, tol_q, tol_d;
    logic [7:0] ref_gap_q, ref_gap_d, fb_gap_q, fb_gap_d;
    plc_src_t src_q, src_d;
    logic rst_req_q, rst_req_d, up_q, up_d, dn_q, dn_d, boot_q, boot_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    plc_analog_t analog_q, analog_d;
    logic wr, rd, mul_wr, ld_match, ld_cmp, ref_fail, fb_fail;
    logic [7:0] diff;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Writes land in the access phase only, so each takes effect once
    assign wr = psel_in & penable_in & pwrite_in & ~pready_q;
    assign rd = psel_in & penable_in & ~pwrite_in & ~pready_q;
    assign mul_wr = wr && paddr_in == OFS_SYNTH_CTRL
        && pwdata_in[POS_FBMUL +: 3] != fb_mul_q;

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_comb begin
        post_div_d = post_div_q;
        fb_mul_d = fb_mul_q;
        pre_div_d = pre_div_q;
        lp_div_d = lp_div_q;
        sync_rst_en_d = sync_rst_en_q;
        cf_det_en_d = cf_det_en_q;
        cf_rst_en_d = cf_rst_en_q;
        synth_en_d = synth_en_q;
        ext_mode_d = ext_mode_q;
        prdata_d = prdata_q;
        pready_d = psel_in & penable_in & ~pready_q;
        pslverr_d = 1'b0;
        if (wr) begin
            case (paddr_in)
                OFS_SYNTH_CTRL: begin
                    // Post-divider sits outside the loop: no lock effect
                    post_div_d = pwdata_in[POS_POSTDIV +: 3]; // [RULE_05]
                    fb_mul_d = pwdata_in[POS_FBMUL +: 3]; // [RULE_04]
                    sync_rst_en_d = pwdata_in[POS_SYNC_RST_EN];
                    cf_det_en_d = pwdata_in[POS_CLKFAIL_DET_EN];
                    cf_rst_en_d = pwdata_in[POS_CLKFAIL_RST_EN];
                    synth_en_d = pwdata_in[POS_SYNTH_EN];
                    ext_mode_d = pwdata_in[POS_EXT_MODE];
                end
                OFS_LOW_POWER: lp_div_d = pwdata_in[3:0];
                OFS_PREDIV: pre_div_d = pwdata_in[2:0];
                OFS_SYNTH_STAT, OFS_RESET_CAUSE, OFS_MONITOR: ;
                default: pslverr_d = 1'b1;
            endcase
        end
        if (rd) begin
            case (paddr_in)
                OFS_SYNTH_CTRL: prdata_d = {19'h0, ext_mode_q, synth_en_q,
                    cf_rst_en_q, cf_det_en_q, sync_rst_en_q, 1'b0,
                    fb_mul_q, 1'b0, post_div_q};
                OFS_SYNTH_STAT: prdata_d = {28'h0, in_sync_q, sticky_cf_q,
                    sticky_q, 1'b0};
                OFS_LOW_POWER: prdata_d = {28'h0, lp_div_q};
                OFS_PREDIV: prdata_d = {29'h0, pre_div_q};
                OFS_RESET_CAUSE: prdata_d = {30'h0, cause_q};
                OFS_MONITOR: prdata_d = {28'h0, ld_q, src_q};
                default: begin
                    prdata_d = 32'h0;
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            post_div_q <= RST_POSTDIV; // [RULE_01]
            fb_mul_q <= RST_FBMUL;
            pre_div_q <= RST_PREDIV;
            lp_div_q <= RST_LPDIV;
            sync_rst_en_q <= 1'b0;
            cf_det_en_q <= 1'b0;
            cf_rst_en_q <= 1'b0;
            synth_en_q <= 1'b1;
            ext_mode_q <= 1'b0;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            post_div_q <= post_div_d;
            fb_mul_q <= fb_mul_d;
            pre_div_q <= pre_div_d;
            lp_div_q <= lp_div_d;
            sync_rst_en_q <= sync_rst_en_d;
            cf_det_en_q <= cf_det_en_d;
            cf_rst_en_q <= cf_rst_en_d;
            synth_en_q <= synth_en_d;
            ext_mode_q <= ext_mode_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ****************************************************************
    // Lock detector
    // ****************************************************************
    // Absolute gap between the two counters
    assign diff = (ref_cnt_q > fb_cnt_q) ? 8'(ref_cnt_q - fb_cnt_q)
                                         : 8'(fb_cnt_q - ref_cnt_q);
    assign ld_cmp = (ld_q == LD_PASS_N && ref_cnt_q == LOCK_N)
        || (ld_q == LD_PASS_NK && ref_cnt_q == LOCK_NK); // [RULE_25]
    assign ld_match = diff <= tol_q;
    // Clock failure: no edge within the window on either detector input
    assign ref_fail = ref_gap_q == CLKFAIL_WIN;
    assign fb_fail = fb_gap_q == CLKFAIL_WIN;

    always_comb begin
        ld_d = ld_q;
        ref_cnt_d = ref_cnt_q + 8'(ref_tick_in);
        fb_cnt_d = fb_cnt_q + 8'(fb_tick_in);
        tol_d = tol_q;
        in_sync_d = in_sync_q;
        sticky_d = sticky_q;
        sticky_save_d = sticky_save_q;
        mul_loss_d = mul_loss_q;
        if (stop_synth_off_in) begin
            // Keep pre-stop sticky value to present after relock
            sticky_save_d = sticky_q; // [RULE_15]
            ld_d = LD_IDLE;
            in_sync_d = 1'b0;
        end else if (ext_mode_q || !synth_en_q || src_q == SRC_SELF
                     || src_q == SRC_STATIC) begin
            ld_d = LD_IDLE; // [RULE_11] [RULE_20]
            in_sync_d = 1'b0;
            sticky_d = 1'b0;
        end else if (mul_wr) begin
            // Multiplier change drops both flags and restarts
            in_sync_d = 1'b0; // [RULE_12]
            sticky_d = 1'b0;
            mul_loss_d = 1'b1;
            tol_d = TOL_TIGHT;
            ld_d = LD_PASS_N;
            ref_cnt_d = 8'h0;
            fb_cnt_d = 8'h0;
        end else if (ld_q == LD_IDLE) begin
            ld_d = LD_PASS_N;
            ref_cnt_d = 8'h0;
            fb_cnt_d = 8'h0;
            sticky_d = sticky_save_q;
            sticky_save_d = 1'b0;
        end else if (ld_cmp) begin
            ref_cnt_d = 8'h0;
            fb_cnt_d = 8'h0;
            if (!ld_match) begin
                // Mismatch: tighten and start over
                in_sync_d = 1'b0; // [RULE_10]
                if (in_sync_q) begin
                    sticky_d = 1'b0; // [RULE_12]
                end
                tol_d = TOL_TIGHT;
                ld_d = LD_PASS_N;
            end else if (ld_q == LD_PASS_N) begin
                ld_d = LD_PASS_NK; // [RULE_09]
            end else begin
                ld_d = LD_PASS_N;
                tol_d = TOL_LOOSE; // [RULE_09]
                if (!in_sync_q) begin
                    in_sync_d = 1'b1; // [RULE_14]
                    // Sticky only after first lock or a deliberate change
                    sticky_d = sticky_q | mul_loss_q | boot_q;
                    mul_loss_d = 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Clock supervision and source selection
    // ****************************************************************
    always_comb begin
        src_d = src_q;
        sticky_cf_d = sticky_cf_q;
        cause_d = cause_q;
        rst_req_d = rst_req_q & ~boot_q; // Held until reset answers
        boot_d = boot_q & ~in_sync_q;
        ref_gap_d = ref_tick_in ? 8'h0 : 8'(ref_gap_q + {7'h0, !ref_fail});
        fb_gap_d = fb_tick_in ? 8'h0 : 8'(fb_gap_q + {7'h0, !fb_fail});
        if (!ext_mode_q && cf_det_en_q) begin // [RULE_11]
            if (ref_fail || fb_fail) begin
                sticky_cf_d = 1'b1; // [RULE_18]
                if (cf_rst_en_q) begin
                    rst_req_d = 1'b1; // [RULE_19]
                    cause_d.clkfail_cause = 1'b1;
                end
            end
            // Reference failure wins over synth failure
            if (ref_fail && src_q != SRC_STATIC) begin
                src_d = self_ok_in ? SRC_SELF : SRC_STATIC; // [RULE_22]
            end else if (fb_fail && src_q == SRC_SYNTH) begin
                src_d = SRC_REF; // [RULE_21]
            end
        end
        if (!ext_mode_q && sync_rst_en_q && in_sync_q && !in_sync_d
            && !mul_wr) begin
            rst_req_d = 1'b1; // [RULE_16]
            cause_d.sync_loss_cause = 1'b1;
        end
        // Synth mode holds reset until locked on a live reference
        if (!ext_mode_q && synth_en_q && src_q == SRC_SYNTH
            && (!in_sync_q || ref_fail) && boot_q) begin
            rst_req_d = 1'b1; // [RULE_17]
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ld_q <= LD_IDLE;
            ref_cnt_q <= 8'h0;
            fb_cnt_q <= 8'h0;
            tol_q <= TOL_TIGHT;
            in_sync_q <= 1'b0;
            sticky_q <= 1'b0;
            sticky_save_q <= 1'b0;
            mul_loss_q <= 1'b0;
            // Flag cleared by reset; cause register keeps history
            sticky_cf_q <= 1'b0;
            src_q <= SRC_SYNTH;
            ref_gap_q <= 8'h0;
            fb_gap_q <= 8'h0;
            rst_req_q <= 1'b1;
            boot_q <= 1'b1;
        end else begin
            ld_q <= ld_d;
            ref_cnt_q <= ref_cnt_d;
            fb_cnt_q <= fb_cnt_d;
            tol_q <= tol_d;
            in_sync_q <= in_sync_d;
            sticky_q <= sticky_d;
            sticky_save_q <= sticky_save_d;
            mul_loss_q <= mul_loss_d;
            sticky_cf_q <= sticky_cf_d;
            src_q <= src_d;
            ref_gap_q <= ref_gap_d;
            fb_gap_q <= fb_gap_d;
            rst_req_q <= rst_req_d;
            boot_q <= boot_d;
        end
    end

    // Cause bits survive the system reset they trigger
    always_ff @(posedge clk_in) begin
        cause_q <= cause_d;
    end

    // ****************************************************************
    // Detector pulses and analog settings
    // ****************************************************************
    always_comb begin
        up_d = fb_lead_in ? 1'b0 : ref_lead_in; // [RULE_06]
        dn_d = ref_lead_in ? 1'b0 : fb_lead_in; // [RULE_06]
        analog_d.pre_div = pre_div_q; // [RULE_23]
        analog_d.fb_mul = fb_mul_q; // [RULE_08]
        analog_d.post_div = post_div_q; // [RULE_05]
        analog_d.lp_div = lp_div_q; // [RULE_02] [RULE_24]
        if (fb_mul_q < 3'h2) begin
            analog_d.pump = 2'h0; // [RULE_07]
        end else if (fb_mul_q < 3'h6) begin
            analog_d.pump = 2'h1;
        end else begin
            analog_d.pump = 2'h2;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            analog_q <= '0;
        end else begin
            up_q <= up_d;
            dn_q <= dn_d;
            analog_q <= analog_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Unlocked synth stays the source while relocking
    assign clk_src_out = src_q; // [RULE_13]
    assign in_sync_out = in_sync_q;
    assign sys_reset_req_out = rst_req_q;
    assign charge_raise_out = up_q;
    assign charge_lower_out = dn_q;
    assign analog_out = analog_q;
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
endmodule : plc_ctrl

// File: logic/plc_pkg.sv
package plc_pkg;
    // ****************************************************************
    // Register offsets (byte addresses on APB)
    // ****************************************************************
    localparam logic [11:0] OFS_SYNTH_CTRL = 12'h000;
    localparam logic [11:0] OFS_SYNTH_STAT = 12'h004;
    localparam logic [11:0] OFS_LOW_POWER = 12'h008;
    localparam logic [11:0] OFS_PREDIV = 12'h00C;
    localparam logic [11:0] OFS_RESET_CAUSE = 12'h010;
    localparam logic [11:0] OFS_MONITOR = 12'h014;

    // ****************************************************************
    // Control register field positions
    // ****************************************************************
    localparam int POS_POSTDIV = 0;
    localparam int POS_FBMUL = 4;
    localparam int POS_SYNC_RST_EN = 8;
    localparam int POS_CLKFAIL_DET_EN = 9;
    localparam int POS_CLKFAIL_RST_EN = 10;
    localparam int POS_SYNTH_EN = 11;
    localparam int POS_EXT_MODE = 12;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    // Post-divider 1 (divide by 2) and multiplier 0 (x4) give 2x reference
    localparam logic [2:0] RST_POSTDIV = 3'h1;
    localparam logic [2:0] RST_FBMUL = 3'h0;
    localparam logic [3:0] RST_LPDIV = 4'h0;
    localparam logic [2:0] RST_PREDIV = 3'h0;

    // ****************************************************************
    // Lock detector counts and clock-failure window
    // ****************************************************************
    localparam logic [7:0] LOCK_N = 8'h40;
    localparam logic [7:0] LOCK_NK = 8'h50;
    localparam logic [7:0] TOL_TIGHT = 8'h01;
    localparam logic [7:0] TOL_LOOSE = 8'h02;
    localparam logic [7:0] CLKFAIL_WIN = 8'hFF;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        SRC_SYNTH = 2'b00,
        SRC_REF = 2'b01,
        SRC_SELF = 2'b10,
        SRC_STATIC = 2'b11
    } plc_src_t;

    typedef enum logic [1:0] {
        LD_PASS_N = 2'b00,
        LD_PASS_NK = 2'b01,
        LD_IDLE = 2'b10
    } plc_ld_t;

    typedef struct packed {
        logic [1:0] pump;
        logic [3:0] lp_div;
        logic [2:0] post_div;
        logic [2:0] fb_mul;
        logic [2:0] pre_div;
    } plc_analog_t;

    typedef struct packed {
        logic sync_loss_cause;
        logic clkfail_cause;
    } plc_cause_t;
endpackage : plc_pkg

// File: tb/plc_ctrl_props.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checker for the clock control block
// ****************************************************************
module plc_ctrl_chk
    import plc_pkg::*;
(
    // Clock, reset and APB handshake
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    // Detector and clock tree
    input wire logic ref_lead_in,
    input wire logic fb_lead_in,
    input wire plc_analog_t analog_out,
    input wire logic charge_raise_out,
    input wire logic charge_lower_out,
    input wire plc_src_t clk_src_out,
    input wire logic in_sync_out,
    input wire logic sys_reset_req_out
);
    // One clock domain; nothing is judged while reset is held
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_apb_answer: assert property (psel_in && penable_in && !pready_out
        |=> pready_out) else $error("access phase not answered");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_pump_map: assert property (
        analog_out.pump == (analog_out.fb_mul < 3'h2 ? 2'h0 :
        analog_out.fb_mul < 3'h6 ? 2'h1 : 2'h2))
        else $error("pump strength does not follow multiplier");
    a_raise_lag: assert property (
        ref_lead_in && !fb_lead_in |=> charge_raise_out && !charge_lower_out)
        else $error("raise not driven while feedback lags");
    a_lower_lead: assert property (
        fb_lead_in && !ref_lead_in |=> charge_lower_out && !charge_raise_out)
        else $error("lower not driven while feedback leads");
    // Reset may only be let go once lock is seen
    a_release_lock: assert property (
        $fell(sys_reset_req_out) |-> in_sync_out)
        else $error("reset released without lock");
    a_self_unlock: assert property (
        clk_src_out == SRC_SELF |=> !in_sync_out)
        else $error("lock reported in self-clocked mode");
    // Fallback sources never return to the synthesizer before the next reset
    a_self_holds: assert property (
        clk_src_out == SRC_SELF |=> clk_src_out inside {SRC_SELF, SRC_STATIC})
        else $error("left self-clocked mode before reset");
    a_static_holds: assert property (
        clk_src_out == SRC_STATIC |=> clk_src_out == SRC_STATIC)
        else $error("left static state before reset");
    a_ref_holds: assert property (
        clk_src_out == SRC_REF |=> clk_src_out != SRC_SYNTH)
        else $error("returned to synthesizer before reset");
endmodule : plc_ctrl_chk

bind plc_ctrl plc_ctrl_chk i_plc_ctrl_chk (.clk_in, .nrst_in, .psel_in,
    .penable_in, .pready_out, .ref_lead_in, .fb_lead_in, .analog_out,
    .charge_raise_out, .charge_lower_out, .clk_src_out, .in_sync_out,
    .sys_reset_req_out);

// File: tb/plc_ref_src.sv
`timescale 1ns/100ps
// ****************************************************************
// Reference and feedback source model
// ****************************************************************
module plc_ref_src (
    // Clock
    input wire logic clk_in,
    // Periods in cycles and source health
    input wire logic [7:0] ref_per_in,
    input wire logic [7:0] fb_per_in,
    input wire logic ref_on_in,
    input wire logic fb_on_in,
    // One-cycle edge strobes
    output logic ref_tick_out,
    output logic fb_tick_out
);
    logic [7:0] rc_q = 8'h00;
    logic [7:0] fc_q = 8'h00;
    // Dividers keep running; a failed source simply stops pulsing
    always @(posedge clk_in) begin
        rc_q <= (rc_q + 8'h01 >= ref_per_in) ? 8'h00 : rc_q + 8'h01;
        fc_q <= (fc_q + 8'h01 >= fb_per_in) ? 8'h00 : fc_q + 8'h01;
        ref_tick_out <= ref_on_in && rc_q == 8'h00;
        fb_tick_out <= fb_on_in && fc_q == 8'h00;
    end
endmodule : plc_ref_src

// File: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    mismatches++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) begin repeat (2000) if (!(c)) @(posedge clk); \
    if (!(c)) mismatches++; end
// ****************************************************************
// Clock control testbench
// ****************************************************************
module tb_top
    import plc_pkg::*;
();
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ref_tick, fb_tick, ref_lead, fb_lead, self_ok, raise, lower;
    logic in_sync, sys_rst, ref_on, fb_on, stop;
    logic [7:0] fb_per;
    plc_analog_t analog;
    plc_src_t src;
    int mismatches = 0;
    int check_count = 0;
    plc_ctrl i_plc_ctrl (.clk_in(clk), .nrst_in(nrst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .ref_tick_in(ref_tick), .fb_tick_in(fb_tick),
        .ref_lead_in(ref_lead), .fb_lead_in(fb_lead), .self_ok_in(self_ok),
        .stop_synth_off_in(stop), .analog_out(analog),
        .charge_raise_out(raise), .charge_lower_out(lower),
        .clk_src_out(src), .in_sync_out(in_sync),
        .sys_reset_req_out(sys_rst));
    plc_ref_src i_plc_ref_src (.clk_in(clk), .ref_per_in(8'h04),
        .fb_per_in(fb_per), .ref_on_in(ref_on), .fb_on_in(fb_on),
        .ref_tick_out(ref_tick), .fb_tick_out(fb_tick));
    // Clock at 250 MHz
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Watchdog well beyond the expected few lock cycles
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // One APB transfer; the leading edge keeps psel from toggling twice
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic do_reset();
        nrst <= 1'h0;
        {self_ok, ref_on, fb_on, fb_per} <= {3'h7, 8'h04};
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
    endtask : do_reset
    // Control word: post-divider, multiplier, enables from bit 8 up
    function automatic logic [31:0] ctl(logic [2:0] f, logic [2:0] p,
            logic [4:0] h);
        return {19'h0, h, 1'h0, f, 1'h0, p};
    endfunction : ctl
    // Reset defaults, dividers, unmapped access, lock and detector
    task automatic t_start();
        apb(1'h0, OFS_SYNTH_CTRL, 32'h0);
        `CHK(rd[12:0], 13'h0801)
        `CHK(sys_rst, 1'h1)
        apb(1'h1, OFS_LOW_POWER, 32'h0000000F);
        apb(1'h1, OFS_PREDIV, 32'h00000007);
        apb(1'h0, 12'h018, 32'h0);
        `CHK(er, 1'h1)
        `CHK(analog.lp_div, 4'hF)
        `CHK(analog.pre_div, 3'h7)
        `CHK({analog.fb_mul, analog.post_div}, 6'h01)
        `WAITC(in_sync === 1'h1)
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK(rd[3:1], 3'h5)
        `CHK(sys_rst, 1'h0)
        ref_lead <= 1'h1;
        repeat (2) @(posedge clk);
        `CHK({raise, lower}, 2'h2)
        {ref_lead, fb_lead} <= 2'h1;
        repeat (2) @(posedge clk);
        `CHK({raise, lower}, 2'h1)
        $display("t_start done");
    endtask : t_start
    // Frequency change procedure across every multiplier code
    task automatic t_pump();
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h0, 3'h2, 5'h08));
        `CHK(in_sync, 1'h1)
        for (int f = 1; f < 8; f++) begin
            apb(1'h1, OFS_SYNTH_CTRL, ctl(f[2:0], 3'h2, 5'h08));
            apb(1'h0, OFS_SYNTH_STAT, 32'h0);
            `CHK(analog.pump, f < 2 ? 2'h0 : f < 6 ? 2'h1 : 2'h2)
            `CHK(rd[3:1], 3'h0)
        end
        `WAITC(in_sync === 1'h1)
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK(rd[3:1], 3'h5)
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h7, 3'h1, 5'h08));
        apb(1'h0, OFS_SYNTH_CTRL, 32'h0);
        `CHK({in_sync, analog.post_div}, 4'h9)
        stop <= 1'h1;
        repeat (20) @(posedge clk);
        stop <= 1'h0;
        `WAITC(in_sync === 1'h1)
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK(rd[3:1], 3'h5)
        $display("t_pump done");
    endtask : t_pump
    // Unexpected loss and relock with the sticky flag left clear
    task automatic t_unlock();
        fb_per <= 8'h05;
        `WAITC(in_sync === 1'h0)
        `CHK({in_sync, src}, {1'h0, SRC_SYNTH})
        fb_per <= 8'h04;
        `WAITC(in_sync === 1'h1)
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK(rd[3:1], 3'h4)
        $display("t_unlock done");
    endtask : t_unlock
    // Feedback loss, reference loss, then both with no self clock
    task automatic t_fail();
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h7, 3'h1, 5'h0A));
        fb_on <= 1'h0;
        `WAITC(src === SRC_REF)
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK({src, rd[2]}, {SRC_REF, 1'h1})
        apb(1'h1, OFS_LOW_POWER, 32'h00000003);
        fb_on <= 1'h1;
        repeat (800) @(posedge clk);
        `CHK({src, analog.lp_div}, {SRC_REF, 4'h3})
        ref_on <= 1'h0;
        `WAITC(src === SRC_SELF && in_sync === 1'h0)
        `CHK({src, in_sync}, {SRC_SELF, 1'h0})
        do_reset();
        `WAITC(in_sync === 1'h1)
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h0, 3'h1, 5'h0A));
        {self_ok, ref_on, fb_on} <= 3'h0;
        `WAITC(src === SRC_STATIC)
        `CHK(src, SRC_STATIC)
        $display("t_fail done");
    endtask : t_fail
    // Resets raised by failure and by loss, then external mode
    task automatic t_resets();
        do_reset();
        `WAITC(in_sync === 1'h1)
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h0, 3'h1, 5'h0E));
        ref_on <= 1'h0;
        `WAITC(sys_rst === 1'h1)
        do_reset();
        apb(1'h0, OFS_RESET_CAUSE, 32'h0);
        `CHK(rd[0], 1'h1)
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK(rd[3:1], 3'h0)
        `WAITC(in_sync === 1'h1)
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h0, 3'h1, 5'h09));
        fb_per <= 8'h05;
        `WAITC(sys_rst === 1'h1)
        do_reset();
        apb(1'h0, OFS_RESET_CAUSE, 32'h0);
        `CHK(rd[1], 1'h1)
        `WAITC(in_sync === 1'h1)
        apb(1'h1, OFS_SYNTH_CTRL, ctl(3'h0, 3'h1, 5'h1F));
        fb_on <= 1'h0;
        repeat (800) @(posedge clk);
        apb(1'h0, OFS_SYNTH_STAT, 32'h0);
        `CHK({rd[3:1], sys_rst}, 4'h0)
        $display("t_resets done");
    endtask : t_resets
    // Main sequence
    initial begin
        {psel, penable, pwrite, ref_lead, fb_lead, nrst, stop} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        do_reset();
        t_start();
        t_pump();
        t_unlock();
        t_fail();
        t_resets();
        final_report();
    end
endmodule : tb_top
